// ===== design/htx_consts.svh
`ifndef HTX_CONSTS_SVH
`define HTX_CONSTS_SVH

// Register byte offsets
`define HTX_OFF_ICR   8'h00
`define HTX_OFF_MODE  8'h04
`define HTX_OFF_CMD   8'h08
`define HTX_OFF_DATA  8'h0C
`define HTX_OFF_STAT  8'h10
`define HTX_OFF_LEN   8'h14
`define HTX_OFF_CNT   8'h18

// interrupt_control_reg fields
`define HTX_ICR_WAIT  7
`define HTX_ICR_LEN   6
`define HTX_ICR_TXIE  1
`define HTX_ICR_TXEN  0
`define HTX_ICR_RST   8'h00

// command_reg code field and codes
`define HTX_CMD_LSB   3
`define HTX_CMD_ABORT 3'h1
`define HTX_CMD_CHRST 3'h3
`define HTX_CMD_RSTPD 3'h5

// transfer_mode_reg encodings
`define HTX_MODE_INT  2'h0
`define HTX_MODE_BINT 2'h1
`define HTX_MODE_DMA  2'h2
`define HTX_MODE_DMA2 2'h3

// Line patterns and CRC
`define HTX_FLAG      8'h7E
`define HTX_CRC_INIT  16'hFFFF
`define HTX_CRC_POLY  16'h8408
`define HTX_STUFF_RUN 3'h5
`define HTX_LAST_BIT  4'h7
`define HTX_LAST_CRC  4'hF

`endif

// ===== design/htx_pkg.sv
package htx_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FLAG,
      ST_DATA,
      ST_CRC,
      ST_ABORT
   } htx_state_e;

   typedef struct packed {
      logic       cha_dma;
      logic       abort;
      logic       pend;
      logic       uflag;
      logic       empty;
   } htx_stat_s;
endpackage

// ===== design/htx_sync.sv
module htx_sync (
   input  wire logic clk_in,
   input  wire logic rstn_in,
   input  wire logic d_in,
   output logic      lvl_out
);
   logic [2:0] s_ff;
   logic       lvl_ff;

   // A change counts once the last two stages agree
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s_ff   <= 3'h0;
         lvl_ff <= 1'b0;
      end else begin
         s_ff <= {s_ff[1:0], d_in};
         if (s_ff[1] == s_ff[2]) begin
            lvl_ff <= s_ff[2];
         end
      end
   end

   assign lvl_out = lvl_ff;
endmodule

// ===== design/htx_crc.sv
`include "htx_consts.svh"
module htx_crc (
   input  wire logic [15:0] crc_in,
   input  wire logic        bit_in,
   output logic      [15:0] crc_out
);
   // Reflected form, data sent LSB first
   wire        fb = crc_in[0] ^ bit_in;
   wire [15:0] sh = {1'b0, crc_in[15:1]};

   assign crc_out = fb ? (sh ^ `HTX_CRC_POLY) : sh;
endmodule

// ===== design/htx_top.sv
// Design decisions made here: the address map and the APB interface to the registers.
`include "htx_consts.svh"
module htx_top #(
   parameter int LEN_W = 16
) (
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic        txclk_in,
   output logic             txd_out,
   output logic             tx_irq_out,
   output logic             tx_dma_request_out,
   output logic             es_event_out,
   output logic             stall_out
);
   generate
      if (LEN_W < 1 || LEN_W > 16) begin : g_chk
         $error("LEN_W must lie in 1..16");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Registers and state
   logic [7:0]        icr_ff;
   logic [1:0]        mode_ff;
   logic [LEN_W-1:0]  tx_length_limit_ff;
   logic [LEN_W-1:0]  cnt_ff;
   logic [31:0]       prdata_ff;
   logic [7:0]        buf_ff;
   logic              full_ff;
   logic              tx_underrun_flag_ff;
   logic              pend_ff;
   logic              armed_ff;
   logic              abort_ff;
   logic              es_ff;
   logic              txd_ff;
   logic              lvl_ff;
   logic [7:0]        sh_ff;
   logic [15:0]       crcsh_ff;
   logic [15:0]       crc_ff;
   logic [3:0]        bcnt_ff;
   logic [2:0]        ones_ff;
   htx_pkg::htx_state_e st_ff;

   ////////////////////////////////////////////////////////////////////////
   // APB decode
   wire acc    = psel_in & penable_in;
   wire setup  = psel_in & ~penable_in;
   wire s_icr  = paddr_in == `HTX_OFF_ICR;
   wire s_mode = paddr_in == `HTX_OFF_MODE;
   wire s_cmd  = paddr_in == `HTX_OFF_CMD;
   wire s_data = paddr_in == `HTX_OFF_DATA;
   wire s_stat = paddr_in == `HTX_OFF_STAT;
   wire s_len  = paddr_in == `HTX_OFF_LEN;
   wire s_cnt  = paddr_in == `HTX_OFF_CNT;
   wire mapped = s_icr | s_mode | s_cmd | s_data | s_stat | s_len | s_cnt;
   wire wr     = acc & pwrite_in & mapped;

   wire wait_en = icr_ff[`HTX_ICR_WAIT];
   wire len_set = icr_ff[`HTX_ICR_LEN];
   wire txie    = icr_ff[`HTX_ICR_TXIE];
   wire tx_en   = icr_ff[`HTX_ICR_TXEN];

   // A data write into a full buffer either waits or is dropped
   wire stall    = wr & s_data & full_ff & wait_en;
   wire wr_take  = wr & s_data & ~full_ff;
   wire [2:0] code = pwdata_in[`HTX_CMD_LSB+2:`HTX_CMD_LSB];
   wire cmd_wr   = wr & s_cmd;
   wire cmd_abt  = cmd_wr & (code == `HTX_CMD_ABORT);
   wire cmd_crst = cmd_wr & (code == `HTX_CMD_CHRST);
   wire cmd_rpd  = cmd_wr & (code == `HTX_CMD_RSTPD);

   // Transfer mode; this block is channel A
   wire cha_dma = mode_ff != `HTX_MODE_INT;

   wire buf_empty = ~full_ff & (st_ff != htx_pkg::ST_CRC);

   htx_pkg::htx_stat_s stat;
   assign stat.cha_dma = cha_dma;
   assign stat.abort   = abort_ff;
   assign stat.pend    = pend_ff;
   assign stat.uflag   = tx_underrun_flag_ff;
   assign stat.empty   = buf_empty;

   wire [31:0] rd_mux =
      s_icr  ? {24'h0, icr_ff} :
      s_mode ? {30'h0, mode_ff} :
      s_stat ? {27'h0, stat} :
      s_len  ? 32'(tx_length_limit_ff) :
      s_cnt  ? 32'(cnt_ff) : 32'h0;

   ////////////////////////////////////////////////////////////////////////
   // Link clock sampling; bits change on the falling link edge
   logic lvl;
   htx_sync u_sync (
      .clk_in  (clk_in),
      .rstn_in (rstn_in),
      .d_in    (txclk_in),
      .lvl_out (lvl)
   );
   wire tick = lvl_ff & ~lvl;

   ////////////////////////////////////////////////////////////////////////
   // Bit engine
   wire in_frame = (st_ff == htx_pkg::ST_DATA) | (st_ff == htx_pkg::ST_CRC);
   wire stuff_ok = in_frame | ((st_ff == htx_pkg::ST_FLAG) &
                   (bcnt_ff == 4'h0));
   wire stuff    = stuff_ok & (ones_ff == `HTX_STUFF_RUN);
   wire cur_bit  = (st_ff == htx_pkg::ST_CRC) ? crcsh_ff[0] :
                   (st_ff == htx_pkg::ST_IDLE) |
                   (st_ff == htx_pkg::ST_ABORT) ? 1'b1 : sh_ff[0];
   wire last_n   = bcnt_ff == ((st_ff == htx_pkg::ST_CRC) ?
                   `HTX_LAST_CRC : `HTX_LAST_BIT);
   wire go_abt   = abort_ff & (st_ff != htx_pkg::ST_ABORT) &
                   (st_ff != htx_pkg::ST_IDLE);
   wire bend     = tick & ~stuff & last_n & ~go_abt;
   wire len_bad  = len_set & (cnt_ff != tx_length_limit_ff);

   logic [15:0] crc_upd;
   htx_crc u_crc (
      .crc_in  (crc_ff),
      .bit_in  (sh_ff[0]),
      .crc_out (crc_upd)
   );

   htx_pkg::htx_state_e nxt_st;
   logic [7:0]  nxt_sh;
   logic [15:0] nxt_crcsh;
   logic [15:0] nxt_crc;
   logic [3:0]  nxt_bcnt;
   logic [2:0]  nxt_ones;
   logic [LEN_W-1:0] nxt_cnt;
   logic        nxt_txd;
   logic        ld_data;
   logic        ld_flag;
   logic        go_under;
   logic        crc_done;
   logic        abt_done;

   always_comb begin
      nxt_st    = st_ff;
      nxt_sh    = sh_ff;
      nxt_crcsh = crcsh_ff;
      nxt_crc   = crc_ff;
      nxt_bcnt  = bcnt_ff;
      nxt_ones  = ones_ff;
      nxt_cnt   = cnt_ff;
      nxt_txd   = txd_ff;
      ld_data   = 1'b0;
      ld_flag   = 1'b0;
      go_under  = 1'b0;
      crc_done  = 1'b0;
      abt_done  = 1'b0;
      if (tick && go_abt) begin
         // Character in progress is dropped on the spot
         nxt_st   = htx_pkg::ST_ABORT;
         nxt_txd  = 1'b1;
         nxt_bcnt = 4'h1;
         nxt_ones = 3'h0;
      end else if (tick && stuff) begin
         nxt_txd  = 1'b0;
         nxt_ones = 3'h0;
      end else if (tick) begin
         nxt_txd  = cur_bit;
         nxt_ones = (in_frame & cur_bit) ? ones_ff + 3'h1 : 3'h0;
         nxt_bcnt = bcnt_ff + 4'h1;
         nxt_sh   = {1'b1, sh_ff[7:1]};
         nxt_crcsh = {1'b1, crcsh_ff[15:1]};
         if (st_ff == htx_pkg::ST_DATA) begin
            nxt_crc = crc_upd;
         end
      end
      if (bend) begin
         nxt_bcnt = 4'h0;
         case (st_ff)
            htx_pkg::ST_IDLE: begin
               if (tx_en) begin
                  ld_flag = 1'b1;
               end
            end
            htx_pkg::ST_FLAG: begin
               if (!tx_en) begin
                  nxt_st = htx_pkg::ST_IDLE;
               end else if (full_ff) begin
                  // First byte opens the frame
                  ld_data = 1'b1;
                  nxt_cnt = LEN_W'(1);
               end else begin
                  ld_flag = 1'b1;
               end
            end
            htx_pkg::ST_DATA: begin
               if (full_ff) begin
                  ld_data = 1'b1;
                  nxt_cnt = cnt_ff + LEN_W'(1);
               end else if (!tx_underrun_flag_ff) begin
                  go_under = 1'b1;
                  if (len_bad) begin
                     nxt_st = htx_pkg::ST_ABORT;
                  end else begin
                     nxt_st    = htx_pkg::ST_CRC;
                     nxt_crcsh = ~crc_upd;
                  end
               end else begin
                  ld_flag = 1'b1;
               end
            end
            htx_pkg::ST_CRC: begin
               crc_done = 1'b1;
               if (tx_en) begin
                  ld_flag = 1'b1;
               end else begin
                  nxt_st = htx_pkg::ST_IDLE;
               end
            end
            htx_pkg::ST_ABORT: begin
               // Eight ones; up to five data ones may precede them
               abt_done = 1'b1;
               ld_flag  = tx_en;
               nxt_st   = tx_en ? htx_pkg::ST_FLAG : htx_pkg::ST_IDLE;
            end
            default: begin
               nxt_st = htx_pkg::ST_IDLE;
            end
         endcase
         if (ld_data) begin
            nxt_st = htx_pkg::ST_DATA;
            nxt_sh = buf_ff;
         end
         if (ld_flag) begin
            nxt_st  = htx_pkg::ST_FLAG;
            nxt_sh  = `HTX_FLAG;
            nxt_crc = `HTX_CRC_INIT;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Host-side flags; hardware sets win over all clears but the channel reset
   wire soft_rst = cmd_crst;
   wire pend_set = txie & tx_en &
                   ((ld_data & (armed_ff | len_set)) |
                    (ld_flag & len_set & ~full_ff) |
                    (ld_flag & crc_done) |
                    cmd_abt);
   wire pend_clr = wr_take | (cmd_rpd & buf_empty);
   wire uf_set   = go_under | soft_rst;
   wire nxt_uf   = uf_set | (tx_underrun_flag_ff & ~ld_data);

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         icr_ff             <= `HTX_ICR_RST;
         mode_ff            <= `HTX_MODE_INT;
         tx_length_limit_ff <= '0;
         prdata_ff          <= 32'h0;
      end else begin
         if (wr && s_icr) begin
            icr_ff <= pwdata_in[7:0];
         end
         if (wr && s_mode) begin
            mode_ff <= pwdata_in[1:0];
         end
         if (wr && s_len) begin
            tx_length_limit_ff <= pwdata_in[LEN_W-1:0];
         end
         if (setup) begin
            prdata_ff <= rd_mux;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         full_ff             <= 1'b0;
         buf_ff              <= 8'h00;
         tx_underrun_flag_ff <= 1'b1;
         es_ff               <= 1'b0;
      end else begin
         if (wr_take) begin
            full_ff <= 1'b1;
            buf_ff  <= pwdata_in[7:0];
         end else if (ld_data || cmd_abt || soft_rst) begin
            full_ff <= 1'b0;
         end
         tx_underrun_flag_ff <= nxt_uf;
         es_ff <= nxt_uf & ~tx_underrun_flag_ff;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pend_ff  <= 1'b0;
         armed_ff <= 1'b0;
         abort_ff <= 1'b0;
      end else begin
         pend_ff  <= ~soft_rst & (pend_set | (pend_ff & ~pend_clr));
         armed_ff <= ~soft_rst & tx_en & (armed_ff | wr_take);
         abort_ff <= ~soft_rst & (cmd_abt | (abort_ff & ~abt_done));
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_ff    <= htx_pkg::ST_IDLE;
         sh_ff    <= 8'hFF;
         crcsh_ff <= 16'hFFFF;
         crc_ff   <= `HTX_CRC_INIT;
         bcnt_ff  <= 4'h0;
         ones_ff  <= 3'h0;
         cnt_ff   <= '0;
         txd_ff   <= 1'b1;
         lvl_ff   <= 1'b0;
      end else begin
         lvl_ff <= lvl;
         if (soft_rst) begin
            st_ff   <= htx_pkg::ST_IDLE;
            bcnt_ff <= 4'h0;
            ones_ff <= 3'h0;
            txd_ff  <= 1'b1;
         end else begin
            st_ff    <= nxt_st;
            sh_ff    <= nxt_sh;
            crcsh_ff <= nxt_crcsh;
            crc_ff   <= nxt_crc;
            bcnt_ff  <= nxt_bcnt;
            ones_ff  <= nxt_ones;
            cnt_ff   <= nxt_cnt;
            txd_ff   <= nxt_txd;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign prdata_out  = prdata_ff;
   assign pready_out  = ~stall;
   assign stall_out   = stall;
   assign pslverr_out = acc & ~mapped;
   assign txd_out     = txd_ff;
   assign es_event_out       = es_ff;
   assign tx_irq_out         = pend_ff & ~cha_dma;
   assign tx_dma_request_out = pend_ff & cha_dma & buf_empty;
endmodule

// ===== tb/htx_top_asserts.sv
`include "htx_consts.svh"
module htx_top_chk #(
   parameter int LEN_W = 16
) (
   input wire logic        clk_in,
   input wire logic        rstn_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [7:0]  paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   input wire logic        txclk_in,
   input wire logic        txd_out,
   input wire logic        tx_irq_out,
   input wire logic        tx_dma_request_out,
   input wire logic        es_event_out,
   input wire logic        stall_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] mode_ff;
   logic [1:0] nxt_mode;
   wire logic  wr_done = psel_in && penable_in && pready_out && pwrite_in;
   wire logic  data_wr = wr_done && paddr_in == `HTX_OFF_DATA;
   wire logic  rstpd_wr = wr_done && paddr_in == `HTX_OFF_CMD
                          && pwdata_in[5:3] == `HTX_CMD_RSTPD;
   wire logic  mode_wr = wr_done && paddr_in == `HTX_OFF_MODE;
   wire logic  crst_wr = wr_done && paddr_in == `HTX_OFF_CMD
                         && pwdata_in[5:3] == `HTX_CMD_CHRST;
   assign nxt_mode = mode_wr ? pwdata_in[1:0] : mode_ff;
   // Mode mirrored from the bus, so no internal signal is needed
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mode_ff <= `HTX_MODE_INT;
      end else begin
         mode_ff <= nxt_mode;
      end
   end
   ////////////////////////////////////////
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   a_stall_data_wr: assert property (
      stall_out |-> psel_in && penable_in && pwrite_in
         && paddr_in == `HTX_OFF_DATA) else $error("stall off a data write");
   a_irq_int_mode: assert property (
      tx_irq_out |-> mode_ff == 2'h0 || $past(mode_ff) == 2'h0)
      else $error("irq outside interrupt mode");
   a_dma_dma_mode: assert property (
      tx_dma_request_out |-> mode_ff != 2'h0 || $past(mode_ff) != 2'h0)
      else $error("dma request in interrupt mode");
   a_req_clr_wr: assert property (
      data_wr |=> !tx_irq_out && !tx_dma_request_out)
      else $error("request kept after data write");
   a_rstpd_clr: assert property (
      rstpd_wr |=> !tx_irq_out && !tx_dma_request_out)
      else $error("request kept after reset pending");
   a_es_pulse: assert property (
      es_event_out |=> !es_event_out) else $error("status event too long");
   a_es_after_rst: assert property (
      $rose(rstn_in) |-> !es_event_out [*8]) else $error("event after reset");
   a_txd_link_edge: assert property (
      // Channel reset idles the line at once, off the link edge
      $changed(txd_out) && !$past(crst_wr) |-> !$past(txclk_in, 2))
      else $error("line bit moved off link fall");
   c_es: cover property (es_event_out);
   c_stall: cover property (stall_out);
   c_dma: cover property ($rose(tx_dma_request_out));
endmodule

bind htx_top htx_top_chk #(.LEN_W(LEN_W)) htx_top_chk_i (
   .clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pwdata_in(pwdata_in), .prdata_out(prdata_out),
   .pready_out(pready_out), .pslverr_out(pslverr_out),
   .txclk_in(txclk_in), .txd_out(txd_out), .tx_irq_out(tx_irq_out),
   .tx_dma_request_out(tx_dma_request_out),
   .es_event_out(es_event_out), .stall_out(stall_out)
);

// ===== tb/htx_link_rx.sv
`include "htx_consts.svh"
module htx_link_rx (
   input  wire logic        clr_in,
   input  wire logic        txd_in,
   output logic             txclk_out,
   output logic [7:0]       max_run_out,
   output logic [15:0]      flags_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] shift_ff;
   logic [7:0] run_ff;
   wire logic [7:0] nxt_shift = {txd_in, shift_ff[7:1]};
   wire logic [7:0] nxt_run = txd_in ? run_ff + 8'h01 : 8'h00;
   initial txclk_out = 1'b0;
   // Runs free: an enabled line idles on flags
   always #80 txclk_out = ~txclk_out;
   // Sampled mid-bit, half a period after the falling link edge that the transmitter moves on
   always @(posedge txclk_out or posedge clr_in) begin
      if (clr_in) begin
         shift_ff <= 8'h00;
         run_ff <= 8'h00;
         max_run_out <= 8'h00;
         flags_out <= 16'h0000;
      end else begin
         shift_ff <= nxt_shift;
         run_ff <= nxt_run;
         if (nxt_run > max_run_out) begin
            max_run_out <= nxt_run;
         end
         if (nxt_shift == `HTX_FLAG) begin
            flags_out <= flags_out + 16'h0001;
         end
      end
   end
endmodule

// ===== tb/htx_top_tb.sv
`include "htx_consts.svh"
module htx_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_in = 1'b0;
   logic        rstn_in = 1'b0;
   logic        psel_in = 1'b0;
   logic        penable_in = 1'b0;
   logic        pwrite_in = 1'b0;
   logic [7:0]  paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0;
   logic [31:0] prdata_out;
   logic [31:0] rd;
   logic [7:0]  max_run;
   logic [15:0] flags;
   logic        pready_out, pslverr_out, txclk_in, txd_out, tx_irq_out;
   logic        tx_dma_request_out, es_event_out, stall_out, err;
   logic        clr = 1'b0;
   logic        saw_stall = 1'b0;
   int          failures = 0;
   int          compares = 0;
   always #2 clk_in = ~clk_in;
   htx_top #(.LEN_W(16)) htx_top_i (
      .clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out),
      .pready_out(pready_out), .pslverr_out(pslverr_out),
      .txclk_in(txclk_in), .txd_out(txd_out), .tx_irq_out(tx_irq_out),
      .tx_dma_request_out(tx_dma_request_out),
      .es_event_out(es_event_out), .stall_out(stall_out));
   htx_link_rx htx_link_rx_i (.clr_in(clr), .txd_in(txd_out),
      .txclk_out(txclk_in), .max_run_out(max_run), .flags_out(flags));
   ////////////////////////////////////////
   task automatic complete_run();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_up();
      failures++;
      $display("[ERR] %0t wait ran out", $time);
      complete_run();
   endtask
   // Ready, read data and error are all taken at the same rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      logic ok;
      ok = 1'b0;
      @(posedge clk_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      for (int n = 0; n < 4000 && ok !== 1'b1; n++) begin
         @(posedge clk_in);
         ok = pready_out;
         rd = prdata_out;
         err = pslverr_out;
         saw_stall = saw_stall | stall_out;
      end
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      if (ok !== 1'b1) give_up();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                        input logic [31:0] mask);
      apb(1'b0, a, 32'h0);
      check(rd & mask, exp);
   endtask
   // Sel 0 irq, 1 dma request, 2 status event
   task automatic await(input int s, input int lim);
      logic hit;
      hit = 1'b0;
      for (int n = 0; n < lim && hit !== 1'b1; n++) begin
         @(negedge clk_in);
         hit = s == 0 ? tx_irq_out : s == 1 ? tx_dma_request_out
             : es_event_out;
      end
      if (hit !== 1'b1) give_up();
   endtask
   task automatic bits(input int n);
      repeat (n * 40) @(posedge clk_in);
   endtask
   task automatic pclr();
      @(posedge clk_in);
      clr <= 1'b1;
      @(posedge clk_in);
      clr <= 1'b0;
   endtask
   function automatic logic [31:0] icr(input logic w, input logic l);
      return {24'h0, w, l, 6'h03};
   endfunction
   function automatic logic [31:0] stat(input logic p, input logic u,
                                        input logic e);
      return {29'h0, p, u, e};
   endfunction
   ////////////////////////////////////////
   initial begin
      void'($urandom(32'h42BD050B));
      repeat (2) @(posedge clk_in);
      rstn_in <= 1'b1;
      rdchk(`HTX_OFF_STAT, stat(0, 1, 1), 32'h7);
      apb(1'b0, 8'h1C, 32'h0);
      check(err, 1'b1);
      for (int m = 0; m < 4; m++) begin
         wr(`HTX_OFF_MODE, 32'(m));
         rdchk(`HTX_OFF_STAT, {27'h0, m != 0, 4'h0}, 32'h10);
      end
      wr(`HTX_OFF_MODE, 32'h0);
      wr(`HTX_OFF_ICR, icr(0, 0));
      bits(4);
      pclr();
      bits(24);
      check(tx_irq_out, 1'b0);
      check(max_run, 8'h06);
      for (int i = 0; i < 4; i++) begin
         if (i > 0) await(0, 4000);
         wr(`HTX_OFF_DATA, i == 1 ? 32'hFF : 32'($urandom) & 32'hFF);
      end
      await(0, 4000);
      rdchk(`HTX_OFF_STAT, stat(1, 0, 1), 32'h7);
      wr(`HTX_OFF_CMD, {26'h0, `HTX_CMD_RSTPD, 3'h0});
      await(2, 4000);
      rdchk(`HTX_OFF_STAT, stat(0, 1, 0), 32'h3);
      check(tx_irq_out, 1'b0);
      bits(40);
      rdchk(`HTX_OFF_STAT, stat(0, 1, 1), 32'h3);
      check(tx_irq_out, 1'b1);
      check(max_run, 8'h06);
      wr(`HTX_OFF_ICR, icr(1, 0));
      wr(`HTX_OFF_DATA, 32'($urandom) & 32'hFF);
      wr(`HTX_OFF_DATA, 32'($urandom) & 32'hFF);
      check(saw_stall, 1'b1);
      await(2, 4000);
      pclr();
      wr(`HTX_OFF_CMD, {26'h0, `HTX_CMD_ABORT, 3'h0});
      rdchk(`HTX_OFF_STAT, 32'h8, 32'h8);
      bits(24);
      check(max_run >= 8 && max_run <= 13, 1'b1);
      check(flags != 0, 1'b1);
      rdchk(`HTX_OFF_STAT, 32'h0, 32'h8);
      wr(`HTX_OFF_MODE, 32'h1);
      wr(`HTX_OFF_LEN, 32'h3);
      rdchk(`HTX_OFF_LEN, 32'h3, 32'hFFFF);
      wr(`HTX_OFF_CMD, {26'h0, `HTX_CMD_RSTPD, 3'h0});
      @(posedge clk_in);
      check(tx_dma_request_out, 1'b0);
      wr(`HTX_OFF_ICR, icr(0, 1));
      await(1, 4000);
      for (int i = 0; i < 2; i++) begin
         wr(`HTX_OFF_DATA, 32'($urandom) & 32'hFF);
         await(1, 4000);
      end
      pclr();
      bits(40);
      check(max_run >= 8, 1'b1);
      wr(`HTX_OFF_CMD, {26'h0, `HTX_CMD_CHRST, 3'h0});
      rdchk(`HTX_OFF_STAT, stat(0, 1, 1), 32'h7);
      complete_run();
   end
endmodule
